// ==== rtl/pic_i2c_port.sv ====
`timescale 1ns/1ps
// How it works
// - target for 100k and 400k transfers
// - offset zero write selects the page
// - address upper five bits are 01011
// - strap code gives two low address bits
// - subaddress and writes use direction zero
// - ack address, subaddress and every written data byte
// - store byte, then subaddress plus one
// - first read byte from loaded subaddress
// - acked read byte advances subaddress by one
// - offset 7F on page zero selects book
// - book0 page0 offset 2 sets modulation
// - volume word at 0x24, book 8C page 2A
module pic_i2c_port
   import pic_pkg::*;
(
   input  wire logic        ref_clk,      // 100 MHz system clock
   input  wire logic        rst_b,        // async reset, low active
   input  wire logic        scl,          // bus clock line
   input  wire logic        sdaIn,        // bus data line level
   output logic             sdaOut,       // data drive level, always low
   output logic             sdaOe,        // high while pulling data low
   input  wire logic [1:0]  adrStrap,     // decoded strap resistor code
   output logic [7:0]       bookSel,      // active book
   output logic [7:0]       pageSel,      // active page
   output logic [7:0]       modCtrl,      // modulation control byte
   output logic [31:0]      volWord,      // digital volume word
   output logic [23:0]      memAddr,      // book, page, subaddress
   output logic [7:0]       memWdata,     // write data to memory
   output logic             memWr,        // one-cycle memory write
   input  wire logic [7:0]  memRdata      // memory byte at memAddr
);

   // ----------------------------------------------------------------
   // reset synchroniser
   // ----------------------------------------------------------------
   logic rstMeta_q;                       // first stage
   logic rstSync_q;                       // released reset for the design

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         rstMeta_q <= 1'b0;
         rstSync_q <= 1'b0;
      end else begin
         rstMeta_q <= 1'b1;
         rstSync_q <= rstMeta_q;
      end
   end

   // ----------------------------------------------------------------
   // line events
   // ----------------------------------------------------------------
   pic_bus_ev_t ev;                       // edges and conditions

   pic_line_sampler uSampler (
      .ref_clk   (ref_clk),
      .rstSync_b (rstSync_q),
      .scl       (scl),
      .sdaIn     (sdaIn),
      .busEv     (ev)
   );

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   pic_state_t  state_q, state_d;         // protocol state
   logic [3:0]  bitCnt_q, bitCnt_d;       // bits moved in this byte
   logic [7:0]  shift_q, shift_d;         // byte shifter, both ways
   logic [7:0]  sub_q, sub_d;             // subaddress
   logic [7:0]  page_q, page_d;           // page selection
   logic [7:0]  book_q, book_d;           // book selection
   logic [7:0]  mod_q, mod_d;             // modulation byte
   logic [31:0] vol_q, vol_d;             // volume word
   logic        oe_q, oe_d;               // data line pull
   logic        mack_q, mack_d;           // host acked last read byte
   logic        wrPulse;                  // write strobe this cycle
   logic [6:0]  devAddr_q;                // own address
   logic        strapDone_q;              // strap captured

   // ----------------------------------------------------------------
   // strap capture after reset release
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge rstSync_q) begin
      if (!rstSync_q) begin
         devAddr_q   <= 7'h00;
         strapDone_q <= 1'b0;
      end else if (!strapDone_q) begin
         devAddr_q   <= {PIC_ADDR_PREFIX, adrStrap};
         strapDone_q <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // decode
   // ----------------------------------------------------------------
   wire       byteDone  = (bitCnt_q == PIC_BYTE_BITS);
   wire       addrHit   = (shift_q[7:1] == devAddr_q) && strapDone_q;
   wire       rdDir     = shift_q[0];
   wire       hitPage   = (sub_q == PIC_PAGE_OFS);
   wire       hitBook   = (sub_q == PIC_BOOK_OFS) && (page_q == 8'h00);
   wire       hitMod    = (sub_q == PIC_MOD_OFS) && (page_q == 8'h00) && (book_q == 8'h00);
   wire       volPage   = (book_q == PIC_VOL_BOOK) && (page_q == PIC_VOL_PAGE);
   wire [7:0] volIdx    = sub_q - PIC_VOL_OFS;
   wire       hitVol    = volPage && (sub_q >= PIC_VOL_OFS) && (volIdx < 8'h04);
   wire [1:0] volLane   = 2'h3 - volIdx[1:0];                         // first byte is MSB
   wire [7:0] volByte   = vol_q[{volLane, 3'b000} +: 8];
   wire [7:0] readByte  = hitPage ? page_q :
                          hitBook ? book_q :
                          hitMod  ? mod_q  :
                          hitVol  ? volByte : memRdata;

   // ----------------------------------------------------------------
   // next-state logic
   // ----------------------------------------------------------------
   always_comb begin
      state_d  = state_q;
      bitCnt_d = bitCnt_q;
      shift_d  = shift_q;
      sub_d    = sub_q;
      page_d   = page_q;
      book_d   = book_q;
      mod_d    = mod_q;
      vol_d    = vol_q;
      oe_d     = oe_q;
      mack_d   = mack_q;
      wrPulse  = 1'b0;
      if (ev.start) begin
         // start or repeated start, sub kept for reads
         state_d  = PIC_ADDR;
         bitCnt_d = 4'h0;
         oe_d     = 1'b0;
      end else if (ev.stop) begin
         state_d  = PIC_IDLE;
         oe_d     = 1'b0;
      end else begin
         case (state_q)
            PIC_IDLE: begin
               oe_d = 1'b0;
            end
            PIC_ADDR, PIC_SUB, PIC_WDATA: begin
               if (ev.sclRise && !byteDone) begin
                  shift_d  = {shift_q[6:0], ev.sda};
                  bitCnt_d = bitCnt_q + 4'h1;
               end else if (ev.sclFall && byteDone) begin
                  bitCnt_d = 4'h0;
                  oe_d     = 1'b1;
                  if (state_q == PIC_ADDR) begin
                     state_d = addrHit ? PIC_ADDR_ACK : PIC_IDLE;
                     oe_d    = addrHit;
                  end else if (state_q == PIC_SUB) begin
                     state_d = PIC_SUB_ACK;
                     sub_d   = shift_q;
                  end else begin
                     // store at sub, then advance
                     state_d = PIC_WDAT_ACK;
                     wrPulse = 1'b1;
                     sub_d   = sub_q + 8'h01;
                     if (hitPage) page_d = shift_q;
                     if (hitBook) book_d = shift_q;
                     if (hitMod)  mod_d  = shift_q;
                     if (hitVol)  vol_d[{volLane, 3'b000} +: 8] = shift_q;
                  end
               end
            end
            PIC_ADDR_ACK: begin
               if (ev.sclFall) begin
                  if (rdDir) begin
                     state_d  = PIC_RDATA;
                     shift_d  = readByte;
                     oe_d     = ~readByte[7];
                     bitCnt_d = 4'h1;
                  end else begin
                     state_d  = PIC_SUB;
                     oe_d     = 1'b0;
                  end
               end
            end
            PIC_SUB_ACK, PIC_WDAT_ACK: begin
               if (ev.sclFall) begin
                  state_d = PIC_WDATA;
                  oe_d    = 1'b0;
               end
            end
            PIC_RDATA: begin
               if (ev.sclFall) begin
                  if (byteDone) begin
                     state_d = PIC_RACK;
                     oe_d    = 1'b0;
                  end else begin
                     shift_d  = {shift_q[6:0], 1'b0};
                     oe_d     = ~shift_q[6];
                     bitCnt_d = bitCnt_q + 4'h1;
                  end
               end
            end
            PIC_RACK: begin
               if (ev.sclRise) begin
                  mack_d = ~ev.sda;
                  if (!ev.sda) sub_d = sub_q + 8'h01;
               end else if (ev.sclFall) begin
                  if (mack_q) begin
                     state_d  = PIC_RDATA;
                     shift_d  = readByte;
                     oe_d     = ~readByte[7];
                     bitCnt_d = 4'h1;
                  end else begin
                     state_d  = PIC_IDLE;
                  end
               end
            end
            default: begin
               state_d = PIC_IDLE;
               oe_d    = 1'b0;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // protocol flip-flops
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge rstSync_q) begin
      if (!rstSync_q) begin
         state_q  <= PIC_IDLE;
         bitCnt_q <= 4'h0;
         shift_q  <= 8'h00;
         sub_q    <= 8'h00;
         oe_q     <= 1'b0;
         mack_q   <= 1'b0;
      end else begin
         state_q  <= state_d;
         bitCnt_q <= bitCnt_d;
         shift_q  <= shift_d;
         sub_q    <= sub_d;
         oe_q     <= oe_d;
         mack_q   <= mack_d;
      end
   end

   // ----------------------------------------------------------------
   // selection and control registers, memory strobe
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge rstSync_q) begin
      if (!rstSync_q) begin
         page_q   <= PIC_PAGE_RESET;
         book_q   <= PIC_BOOK_RESET;
         mod_q    <= PIC_MOD_RESET;
         vol_q    <= PIC_VOL_RESET;
         memAddr  <= 24'h000000;
         memWdata <= 8'h00;
         memWr    <= 1'b0;
      end else begin
         page_q   <= page_d;
         book_q   <= book_d;
         mod_q    <= mod_d;
         vol_q    <= vol_d;
         memAddr  <= {book_q, page_q, sub_q};
         memWdata <= wrPulse ? shift_q : memWdata;
         memWr    <= wrPulse;
      end
   end

   // ----------------------------------------------------------------
   // outputs straight from flops, data drive level tied low
   // ----------------------------------------------------------------
   assign sdaOut  = 1'b0;
   assign sdaOe   = oe_q;
   assign bookSel = book_q;
   assign pageSel = page_q;
   assign modCtrl = mod_q;
   assign volWord = vol_q;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   wire wrDone = (state_q == PIC_WDATA) && ev.sclFall && byteDone && !ev.start && !ev.stop;

   pageWrite_a: assert property (@(posedge ref_clk) disable iff (!rstSync_q)
      wrDone && hitPage |=> page_q == $past(shift_q))
      else $error("page write not taken");
   bookWrite_a: assert property (@(posedge ref_clk) disable iff (!rstSync_q)
      wrDone && (sub_q == PIC_BOOK_OFS) |=> book_q == ($past(page_q) == 8'h00 ?
         $past(shift_q) : $past(book_q)))
      else $error("book write wrong");
   addrMiss_a: assert property (@(posedge ref_clk) disable iff (!rstSync_q)
      (state_q == PIC_ADDR) && ev.sclFall && byteDone && !addrHit && !ev.start && !ev.stop
      |=> (state_q == PIC_IDLE && !sdaOe) [*3])
      else $error("foreign address answered");
   ackHeld_a: assert property (@(posedge ref_clk) disable iff (!rstSync_q)
      $rose(state_q == PIC_SUB_ACK) |-> sdaOe throughout (state_q == PIC_SUB_ACK) [*2])
      else $error("ack not driven");
   subInc_a: assert property (@(posedge ref_clk) disable iff (!rstSync_q)
      wrDone |=> sub_q == $past(sub_q) + 8'h01 && memWr && memWdata == $past(shift_q))
      else $error("write did not advance or strobe");
   readLoad_a: assert property (@(posedge ref_clk) disable iff (!rstSync_q)
      (state_q == PIC_ADDR_ACK) && rdDir && ev.sclFall && !ev.start && !ev.stop
      |=> state_q == PIC_RDATA && shift_q == $past(readByte) && sdaOe == !shift_q[7])
      else $error("read byte not loaded");
   readInc_a: assert property (@(posedge ref_clk) disable iff (!rstSync_q)
      (state_q == PIC_RACK) && ev.sclRise && !ev.sda && !ev.start && !ev.stop
      |=> sub_q == $past(sub_q) + 8'h01 && mack_q)
      else $error("acked read did not advance");
   modWrite_a: assert property (@(posedge ref_clk) disable iff (!rstSync_q)
      wrDone && hitMod |=> modCtrl == $past(shift_q))
      else $error("modulation byte not stored");
   volWrite_a: assert property (@(posedge ref_clk) disable iff (!rstSync_q)
      wrDone && volPage && (sub_q == PIC_VOL_OFS) |=> volWord[31:24] == $past(shift_q))
      else $error("volume top byte not stored");
   ownAddr_a: assert property (@(posedge ref_clk) disable iff (!rstSync_q)
      strapDone_q && $past(strapDone_q) |-> devAddr_q[6:2] == PIC_ADDR_PREFIX &&
         $stable(devAddr_q))
      else $error("own address changed");

endmodule : pic_i2c_port

// ==== rtl/pic_pkg.sv ====
package pic_pkg;

   // ----------------------------------------------------------------
   // target address
   // ----------------------------------------------------------------
   localparam logic [4:0]  PIC_ADDR_PREFIX = 5'h0B;       // fixed upper address bits 01011

   // ----------------------------------------------------------------
   // register offsets inside a page
   // ----------------------------------------------------------------
   localparam logic [7:0]  PIC_PAGE_OFS    = 8'h00;       // page selector, every page
   localparam logic [7:0]  PIC_BOOK_OFS    = 8'h7F;       // book selector, page zero only
   localparam logic [7:0]  PIC_MOD_OFS     = 8'h02;       // modulation control, book 0 page 0
   localparam logic [7:0]  PIC_VOL_OFS     = 8'h24;       // first byte of volume word
   localparam logic [7:0]  PIC_VOL_BOOK    = 8'h8C;       // host-memory book
   localparam logic [7:0]  PIC_VOL_PAGE    = 8'h2A;       // host-memory page of volume

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [7:0]  PIC_PAGE_RESET  = 8'h00;       // page zero after reset
   localparam logic [7:0]  PIC_BOOK_RESET  = 8'h00;       // book zero after reset
   localparam logic [7:0]  PIC_MOD_RESET   = 8'h00;       // 768 kHz, in-phase two-level
   localparam logic [31:0] PIC_VOL_RESET   = 32'h0080_0000; // unity gain

   // ----------------------------------------------------------------
   // bus framing
   // ----------------------------------------------------------------
   localparam logic [3:0]  PIC_BYTE_BITS   = 4'h8;        // bits in one byte

   // bus events seen on the two lines, one cycle each, plus the data line level
   typedef struct packed {
      logic sclRise;                                      // clock line went high
      logic sclFall;                                      // clock line went low
      logic start;                                        // data fell while clock high
      logic stop;                                         // data rose while clock high
      logic sda;                                          // data line level
   } pic_bus_ev_t;

   // target state
   typedef enum logic [3:0] {
      PIC_IDLE     = 4'b0000,
      PIC_ADDR     = 4'b0001,
      PIC_ADDR_ACK = 4'b0010,
      PIC_SUB      = 4'b0011,
      PIC_SUB_ACK  = 4'b0100,
      PIC_WDATA    = 4'b0101,
      PIC_WDAT_ACK = 4'b0110,
      PIC_RDATA    = 4'b0111,
      PIC_RACK     = 4'b1000
   } pic_state_t;

endpackage : pic_pkg

// ==== rtl/pic_line_sampler.sv ====
`timescale 1ns/1ps
module pic_line_sampler
   import pic_pkg::*;
(
   input  wire logic        ref_clk,      // system clock
   input  wire logic        rstSync_b,    // synchronised reset, low active
   input  wire logic        scl,          // bus clock line level
   input  wire logic        sdaIn,        // bus data line level
   output pic_bus_ev_t      busEv         // decoded bus events
);

   // ----------------------------------------------------------------
   // previous line levels
   // ----------------------------------------------------------------
   logic sclPrev_q;                       // clock line one cycle ago
   logic sdaPrev_q;                       // data line one cycle ago

   // lines idle high, so reset to high
   always_ff @(posedge ref_clk or negedge rstSync_b) begin
      if (!rstSync_b) begin
         sclPrev_q <= 1'b1;
         sdaPrev_q <= 1'b1;
      end else begin
         sclPrev_q <= scl;
         sdaPrev_q <= sdaIn;
      end
   end

   // ----------------------------------------------------------------
   // edge and condition decode
   // ----------------------------------------------------------------
   assign busEv.sclRise = scl & ~sclPrev_q;
   assign busEv.sclFall = ~scl & sclPrev_q;
   assign busEv.start   = scl & sclPrev_q & sdaPrev_q & ~sdaIn;
   assign busEv.stop    = scl & sclPrev_q & ~sdaPrev_q & sdaIn;
   assign busEv.sda     = sdaIn;

endmodule : pic_line_sampler

// ==== tb/pic_host_model.sv ====
`timescale 1ns/1ps
module pic_host_model (
   input  wire logic  ref_clk,  // system clock
   input  wire logic  sdaLine,  // resolved data line
   output logic       scl,      // bus clock, host driven
   output logic       sdaPull,  // high pulls data low
   output logic [7:0] rdByte,   // last byte read back
   output logic       rdStb     // one-cycle read strobe
);
   int halfCyc = 8;             // cycles per bus clock half
   initial begin
      scl = 1'b1;
      sdaPull = 1'b0;
      rdByte = 8'h00;
      rdStb = 1'b0;
   end
   // ----------------------------------------------
   // line primitives, changed just after an edge
   // ----------------------------------------------
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask : tick
   // start (a=0) or stop (a=1); halfCyc cycles keep clock and data changes apart
   task automatic cond(input logic a, input logic b);
      tick(1);
      sdaPull = a;
      tick(halfCyc);
      scl = 1'b1;
      tick(halfCyc);
      sdaPull = b;
      tick(halfCyc);
      scl = a;
   endtask : cond
   // one bit: drive, then sample at end of high phase
   task automatic bitX(input logic drv, output logic smp);
      tick(1);
      sdaPull = !drv;
      tick(halfCyc);
      scl = 1'b1;
      tick(halfCyc);
      smp = sdaLine;
      scl = 1'b0;
   endtask : bitX
   // byte out, msb first, returns target ack
   task automatic sendByte(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) bitX(b[i], s);
      bitX(1'b1, s);
      ack = !s;
   endtask : sendByte
   // byte in, then ack or nack
   task automatic recvByte(input logic ackIt);
      logic [7:0] b;
      logic       s;
      for (int i = 7; i >= 0; i--) bitX(1'b1, b[i]);
      rdByte = b;
      rdStb = 1'b1;
      tick(1);
      rdStb = 1'b0;
      bitX(!ackIt, s);
   endtask : recvByte
   // start, address+write, subaddress, data bytes, stop
   task automatic writeSeq(input logic [6:0] adr, input logic [7:0] sub,
                           input logic [7:0] dat[$], output logic ok);
      logic a;
      cond(1'b0, 1'b1);
      sendByte({adr, 1'b0}, ok);
      if (ok) begin
         sendByte(sub, a);
         ok &= a;
         foreach (dat[i]) begin
            sendByte(dat[i], a);
            ok &= a;
         end
      end
      cond(1'b1, 1'b0);
   endtask : writeSeq
   // subaddress write, repeated start, address+read, n bytes, stop
   task automatic readSeq(input logic [6:0] adr, input logic [7:0] sub,
                          input int n, output logic ok);
      logic a;
      cond(1'b0, 1'b1);
      sendByte({adr, 1'b0}, ok);
      sendByte(sub, a);
      ok &= a;
      cond(1'b0, 1'b1);
      sendByte({adr, 1'b1}, a);
      ok &= a;
      for (int i = 0; i < n; i++) recvByte(i < n - 1);
      cond(1'b1, 1'b0);
   endtask : readSeq
endmodule : pic_host_model

// ==== tb/paged_i2c_control_port_tb.sv ====
`timescale 1ns/1ps
module paged_i2c_control_port_tb
   import pic_pkg::*;
;
   logic        ref_clk = 1'b0;                   // 100 MHz clock
   logic        rst_b = 1'b0;                     // reset, low active
   logic [1:0]  adrStrap = 2'b00;                 // strap code
   logic        scl, sdaPull, sdaOut, sdaOe, memWr, rdStb, ok;
   logic [7:0]  bookSel, pageSel, modCtrl, memWdata, memRdata, rdByte;
   logic [31:0] volWord;
   logic [23:0] memAddr;
   logic [6:0]  myAdr;                            // address the host uses
   logic [7:0]  mBook, mPage, mMod, mSub;         // reference state
   logic [31:0] mVol;
   logic [7:0]  q[$];                             // payload scratch
   logic [31:0] expWr[$];                         // notes: memory writes
   logic [7:0]  expRd[$];                         // notes: read bytes
   int          n_mismatch = 0;
   int          compares = 0;
   wire         sdaLine = !(sdaPull || (sdaOe && !sdaOut)); // pulled-up wire
   assign memRdata = memAddr[23:16] ^ memAddr[15:8] ^ memAddr[7:0] ^ 8'hA5; // memory stand-in
   always #5 ref_clk = ~ref_clk;
   pic_i2c_port pic_i2c_port_i (.ref_clk(ref_clk), .rst_b(rst_b), .scl(scl), .sdaIn(sdaLine),
      .sdaOut(sdaOut), .sdaOe(sdaOe), .adrStrap(adrStrap), .bookSel(bookSel),
      .pageSel(pageSel), .modCtrl(modCtrl), .volWord(volWord), .memAddr(memAddr),
      .memWdata(memWdata), .memWr(memWr), .memRdata(memRdata));
   pic_host_model pic_host_model_i (.ref_clk(ref_clk), .sdaLine(sdaLine), .scl(scl),
      .sdaPull(sdaPull), .rdByte(rdByte), .rdStb(rdStb));
   // ----------------------------------------------
   // checking and reference model
   // ----------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      compares++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk
   // watcher: oldest note against each result
   always @(negedge ref_clk) begin
      if (memWr === 1'b1) chk({memAddr, memWdata},
         expWr.size() ? expWr.pop_front() : 'X, "mem write");
      if (rdStb === 1'b1) chk({24'h0, rdByte},
         expRd.size() ? {24'h0, expRd.pop_front()} : 'X, "read byte");
   end
   function automatic logic isVol(input logic [7:0] s);
      return mBook == PIC_VOL_BOOK && mPage == PIC_VOL_PAGE && s[7:2] == PIC_VOL_OFS[7:2];
   endfunction : isVol
   function automatic logic [7:0] rdExp(input logic [7:0] s);
      if (s == PIC_PAGE_OFS) return mPage;
      if (s == PIC_BOOK_OFS && mPage == 8'h00) return mBook;
      if (mBook == 8'h00 && mPage == 8'h00 && s == PIC_MOD_OFS) return mMod;
      if (isVol(s)) return mVol[8*(3-s[1:0]) +: 8];
      return mBook ^ mPage ^ s ^ 8'hA5;
   endfunction : rdExp
   // note each byte at its subaddress, then advance
   task automatic wr(input logic [7:0] sub, input logic [7:0] dat[$]);
      mSub = sub;
      foreach (dat[i]) begin
         expWr.push_back({mBook, mPage, mSub, dat[i]});
         if (mSub == PIC_PAGE_OFS) mPage = dat[i];
         else if (mSub == PIC_BOOK_OFS && mPage == 8'h00) mBook = dat[i];
         else if (mBook == 8'h00 && mPage == 8'h00 && mSub == PIC_MOD_OFS) mMod = dat[i];
         else if (isVol(mSub)) mVol[8*(3-mSub[1:0]) +: 8] = dat[i];
         mSub++;
      end
      pic_host_model_i.writeSeq(myAdr, sub, dat, ok);
      chk({31'h0, ok}, 32'h1, "write ack");
   endtask : wr
   task automatic rd(input logic [7:0] sub, input int n);
      for (int i = 0; i < n; i++) expRd.push_back(rdExp(sub + 8'(i)));
      pic_host_model_i.readSeq(myAdr, sub, n, ok);
      chk({31'h0, ok}, 32'h1, "read ack");
   endtask : rd
   task automatic doReset(input logic [1:0] s);
      rst_b = 1'b0;
      adrStrap = s;
      repeat (10) @(posedge ref_clk);
      #1;
      rst_b = 1'b1;
      {mBook, mPage, mMod, mVol} = {24'h0, PIC_VOL_RESET};
      repeat (5) @(posedge ref_clk);
      #1;
   endtask : doReset
   task automatic print_verdict();
      $display("mismatches %0d compares %0d", n_mismatch, compares);
      if (n_mismatch == 0 && compares > 0) begin
         $display("TB: PASS");
      end
      else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : print_verdict
   initial begin
      repeat (90000) @(posedge ref_clk);
      n_mismatch++;
      print_verdict();
   end
   // ----------------------------------------------
   // main sequence
   // ----------------------------------------------
   initial begin
      void'($urandom(32'h6288));
      for (int s = 0; s < 4; s++) begin
         doReset(2'(s));
         chk({8'h0, bookSel, pageSel, modCtrl},
             {8'h0, PIC_BOOK_RESET, PIC_PAGE_RESET, PIC_MOD_RESET}, "reset sel");
         chk(volWord, PIC_VOL_RESET, "reset vol");
         pic_host_model_i.halfCyc = (s == 0) ? 500 : (s == 1) ? 125 : 8;
         myAdr = {PIC_ADDR_PREFIX, 2'(s) + 2'b01};
         pic_host_model_i.writeSeq(myAdr, 8'h00, '{8'h11}, ok);
         chk({31'h0, ok}, 32'h0, "foreign ack");
         myAdr = {PIC_ADDR_PREFIX, 2'(s)};
         wr(8'h00, '{8'h05});
         chk({24'h0, pageSel}, 32'h5, "page");
      end
      wr(8'h00, '{8'h00});
      wr(PIC_BOOK_OFS, '{PIC_VOL_BOOK});
      wr(8'h00, '{PIC_VOL_PAGE});
      wr(PIC_BOOK_OFS, '{8'h33});
      chk({16'h0, bookSel, pageSel}, {16'h0, mBook, mPage}, "book page");
      q = '{8'($urandom), 8'($urandom), 8'($urandom), 8'($urandom)};
      wr(PIC_VOL_OFS, q);
      chk(volWord, mVol, "volume");
      rd(8'h23, 6);
      wr(PIC_VOL_OFS, '{8'h00, 8'h80, 8'h00, 8'h00});
      chk(volWord, PIC_VOL_RESET, "unity");
      rd(8'h00, 2);
      wr(8'h00, '{8'h00});
      wr(PIC_BOOK_OFS, '{8'h00});
      wr(PIC_MOD_OFS, '{8'($urandom) | 8'h01});
      chk({24'h0, modCtrl}, {24'h0, mMod}, "modulation set");
      rd(8'h01, 2);
      wr(PIC_MOD_OFS, '{8'h00});
      chk({24'h0, modCtrl}, 32'h0, "modulation");
      rd(8'h7E, 3);
      wr(PIC_BOOK_OFS, '{8'hAA});
      wr(8'h00, '{8'h01});
      q = {};
      repeat (20) q.push_back(8'($urandom));
      wr(8'h10, q);
      rd(8'h10, 5);
      wr(8'hFF, '{8'h44, 8'h07});
      chk({24'h0, pageSel}, 32'h7, "wrapped page");
      repeat (5) @(posedge ref_clk);
      chk(expWr.size() + expRd.size(), 32'h0, "notes left");
      print_verdict();
   end
endmodule : paged_i2c_control_port_tb
